// [hpp_pkg.sv]
package hpp_pkg;

  localparam int PIN_COUNT = 16;
  localparam int WORD_W = 24;
  localparam int BYTE_W = 8;

  // Port pin control register field positions
  localparam int PC_GPIO_LO = 1;
  localparam int PC_GPIO_HI = 6;
  localparam int PC_MUX_BIT = 11;
  localparam int PC_DUAL_STROBE_BIT = 12;
  localparam int PC_DUAL_REQ_BIT = 13;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // Polarity register bits; zero means active low
  localparam int POL_CS = 0;
  localparam int POL_STROBE = 1;
  localparam int POL_REQ = 2;
  localparam int POL_ACK = 3;
  localparam logic [3:0] POL_RESET = 4'h0;

  // GPIO bit positions
  localparam int PB_DATA_LO = 0;
  localparam int PB_ADDR_LO = 8;
  localparam int PB_STROBE_A = 11;
  localparam int PB_STROBE_B = 12;
  localparam int PB_CS = 13;
  localparam int PB_REQ_A = 14;
  localparam int PB_REQ_B = 15;

  localparam logic [15:0] GPIO_RESET = 16'h0000;
  localparam logic [23:0] WORD_RESET = 24'h000000;

  // Host byte map; transmit and receive bytes share addresses
  localparam logic [2:0] HA_HIGH = 3'h5;
  localparam logic [2:0] HA_MID = 3'h6;
  localparam logic [2:0] HA_LOW = 3'h7;

  // Data word size selection on the DSP side
  localparam logic [1:0] WS_8 = 2'h0;
  localparam logic [1:0] WS_16 = 2'h1;
  localparam logic [1:0] WS_24 = 2'h2;

  typedef struct packed {
    logic [15:0] pin_out;
    logic [15:0] pin_oe_n;
  } hpp_pins_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] size;
    logic [23:0] wdata;
  } hpp_dsp_req_t;

endpackage : hpp_pkg

// [hpp_sync2.sv]
`timescale 1ns/10ps
`default_nettype none
module hpp_sync2 #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // Host pins change on no DSP edge; two stages settle them
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  assign q_o = s2_q;
endmodule : hpp_sync2
`default_nettype wire

// [hpp_host_port.sv]
`timescale 1ns/10ps
`default_nettype none
module hpp_host_port (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic soft_reset_i,
  input wire logic [15:0] pin_in_i,
  output logic [15:0] pin_out_o,
  output logic [15:0] pin_oe_n_o,
  input wire logic [15:0] pin_ctrl_wdata_i,
  input wire logic pin_ctrl_we_i,
  input wire logic [3:0] polarity_wdata_i,
  input wire logic polarity_we_i,
  input wire logic [15:0] gpio_dir_wdata_i,
  input wire logic gpio_dir_we_i,
  input wire logic [15:0] gpio_val_wdata_i,
  input wire logic gpio_val_we_i,
  input wire hpp_pkg::hpp_dsp_req_t dsp_req_i,
  output logic [23:0] dsp_rdata_o,
  output logic [15:0] gpio_pin_value_o,
  output logic [15:0] port_pin_control_o,
  output logic dsp_receive_full_o,
  output logic dsp_send_empty_o
);
  logic [15:0] pin_ctrl_q;
  logic [3:0] pol_q;
  logic [15:0] dir_q;
  logic [15:0] gval_q;
  logic [15:0] pin_s;
  logic host_mode;
  logic mux_mode;
  logic dual_strobe;
  logic dual_req;
  logic cs_act;
  logic rd_act;
  logic wr_act;
  logic ack_act;
  logic rd_prev_q;
  logic wr_prev_q;
  logic as_prev_q;
  logic rd_rise;
  logic wr_fall;
  logic [2:0] addr_d;
  logic [2:0] addr_q;
  logic [23:0] tx_bytes_q;
  logic [23:0] rx_bytes_q;
  logic tx_full_q;
  logic rx_full_q;
  logic [23:0] hrx_q;
  logic hrx_full_q;
  logic [23:0] htx_q;
  logic htx_full_q;
  logic send_empty_q;
  logic [7:0] rd_byte;
  logic [15:0] out_d;
  logic [15:0] oe_n_d;
  logic [15:0] out_q;
  logic [15:0] oe_n_q;
  logic [23:0] dsp_rdata_q;
  logic [15:0] gpin_q;

  // Host pins are asynchronous to this clock
  hpp_sync2 #(.W(hpp_pkg::PIN_COUNT)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(pin_in_i),
    .q_o(pin_s)
  );

  // Control registers; software reset clears them like the pin reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_ctrl_q <= hpp_pkg::PC_RESET;
      pol_q <= hpp_pkg::POL_RESET;
      dir_q <= hpp_pkg::GPIO_RESET;
      gval_q <= hpp_pkg::GPIO_RESET;
    end else if (soft_reset_i) begin
      pin_ctrl_q <= hpp_pkg::PC_RESET;
      pol_q <= hpp_pkg::POL_RESET;
      dir_q <= hpp_pkg::GPIO_RESET;
      gval_q <= hpp_pkg::GPIO_RESET;
    end else begin
      if (pin_ctrl_we_i) pin_ctrl_q <= pin_ctrl_wdata_i;
      if (polarity_we_i) pol_q <= polarity_wdata_i;
      if (gpio_dir_we_i) dir_q <= gpio_dir_wdata_i;
      if (gpio_val_we_i) gval_q <= gpio_val_wdata_i;
    end
  end

  assign host_mode = |pin_ctrl_q[hpp_pkg::PC_GPIO_HI:hpp_pkg::PC_GPIO_LO];
  assign mux_mode = pin_ctrl_q[hpp_pkg::PC_MUX_BIT];
  assign dual_strobe = pin_ctrl_q[hpp_pkg::PC_DUAL_STROBE_BIT];
  assign dual_req = pin_ctrl_q[hpp_pkg::PC_DUAL_REQ_BIT];

  // Polarity bit zero keeps the reset active-low sense
  assign cs_act = mux_mode ? 1'b1
                : (pin_s[hpp_pkg::PB_CS] ^ ~pol_q[hpp_pkg::POL_CS]);
  assign ack_act = pin_s[hpp_pkg::PB_REQ_B] ^ ~pol_q[hpp_pkg::POL_ACK];

  always_comb begin
    if (dual_strobe) begin
      rd_act = pin_s[hpp_pkg::PB_STROBE_A] ^ ~pol_q[hpp_pkg::POL_STROBE];
      wr_act = pin_s[hpp_pkg::PB_STROBE_B] ^ ~pol_q[hpp_pkg::POL_STROBE];
    end else begin
      rd_act = (pin_s[hpp_pkg::PB_STROBE_B] ^ ~pol_q[hpp_pkg::POL_STROBE])
               & pin_s[hpp_pkg::PB_STROBE_A];
      wr_act = (pin_s[hpp_pkg::PB_STROBE_B] ^ ~pol_q[hpp_pkg::POL_STROBE])
               & ~pin_s[hpp_pkg::PB_STROBE_A];
    end
    rd_act = rd_act & cs_act & host_mode;
    wr_act = wr_act & cs_act & host_mode;
  end

  // Address from lines in plain mode, latched at address strobe when muxed
  always_comb begin
    addr_d = addr_q;
    if (!mux_mode) begin
      addr_d = {pin_s[hpp_pkg::PB_ADDR_LO+2], pin_s[hpp_pkg::PB_ADDR_LO+1],
                pin_s[hpp_pkg::PB_ADDR_LO]};
    end else if (as_prev_q && !pin_s[hpp_pkg::PB_ADDR_LO]) begin
      addr_d = pin_s[2:0];
    end
  end

  assign rd_rise = rd_prev_q & ~rd_act;
  assign wr_fall = wr_prev_q & ~wr_act;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
      as_prev_q <= 1'b0;
      addr_q <= 3'h0;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
      as_prev_q <= pin_s[hpp_pkg::PB_ADDR_LO];
      addr_q <= addr_d;
    end
  end

  // Host byte bank: low byte completes a word, reading it frees the receive side
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_bytes_q <= hpp_pkg::WORD_RESET;
      tx_full_q <= 1'b0;
    end else if (wr_fall) begin
      unique case (addr_q)
        hpp_pkg::HA_HIGH: tx_bytes_q[23:16] <= pin_s[7:0];
        hpp_pkg::HA_MID: tx_bytes_q[15:8] <= pin_s[7:0];
        hpp_pkg::HA_LOW: begin
          tx_bytes_q[7:0] <= pin_s[7:0];
          tx_full_q <= 1'b1;
        end
        default: ;
      endcase
    end else if (tx_full_q && !hrx_full_q) begin
      tx_full_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (addr_q)
      hpp_pkg::HA_HIGH: rd_byte = rx_bytes_q[23:16];
      hpp_pkg::HA_MID: rd_byte = rx_bytes_q[15:8];
      hpp_pkg::HA_LOW: rd_byte = rx_bytes_q[7:0];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_bytes_q <= hpp_pkg::WORD_RESET;
      rx_full_q <= 1'b0;
    end else if (!rx_full_q && htx_full_q) begin
      rx_bytes_q <= htx_q;
      rx_full_q <= 1'b1;
    end else if (rd_rise && addr_q == hpp_pkg::HA_LOW) begin
      rx_full_q <= 1'b0;
    end
  end

  // DSP receive word: filled from host bytes, emptied by a DSP read
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hrx_q <= hpp_pkg::WORD_RESET;
      hrx_full_q <= 1'b0;
    end else if (tx_full_q && !hrx_full_q) begin
      hrx_q <= tx_bytes_q;
      hrx_full_q <= 1'b1;
    end else if (dsp_req_i.rd) begin
      hrx_full_q <= 1'b0;
    end
  end

  // DSP send word; narrow writes sit in the low bits
  // The empty flag is a flop of its own so the status output has no gate after it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      htx_q <= hpp_pkg::WORD_RESET;
      htx_full_q <= 1'b0;
      send_empty_q <= 1'b1;
    end else if (dsp_req_i.wr) begin
      unique case (dsp_req_i.size)
        hpp_pkg::WS_8: htx_q <= {16'h0000, dsp_req_i.wdata[7:0]};
        hpp_pkg::WS_16: htx_q <= {8'h00, dsp_req_i.wdata[15:0]};
        default: htx_q <= dsp_req_i.wdata;
      endcase
      htx_full_q <= 1'b1;
      send_empty_q <= 1'b0;
    end else if (htx_full_q && !rx_full_q) begin
      htx_full_q <= 1'b0;
      send_empty_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dsp_rdata_q <= hpp_pkg::WORD_RESET;
    end else begin
      unique case (dsp_req_i.size)
        hpp_pkg::WS_8: dsp_rdata_q <= {16'h0000, hrx_q[7:0]};
        hpp_pkg::WS_16: dsp_rdata_q <= {8'h00, hrx_q[15:0]};
        default: dsp_rdata_q <= hrx_q;
      endcase
    end
  end

  // Pin drivers: host functions override GPIO bits entirely
  always_comb begin
    oe_n_d = ~dir_q;
    out_d = gval_q;
    if (host_mode) begin
      oe_n_d = 16'hffff;
      out_d = 16'h0000;
      if (rd_act) begin
        oe_n_d[7:0] = 8'h00;
        out_d[7:0] = rd_byte;
      end
      if (dual_req) begin
        oe_n_d[hpp_pkg::PB_REQ_A] = 1'b0;
        oe_n_d[hpp_pkg::PB_REQ_B] = 1'b0;
        out_d[hpp_pkg::PB_REQ_A] = ~tx_full_q ^ ~pol_q[hpp_pkg::POL_REQ];
        out_d[hpp_pkg::PB_REQ_B] = rx_full_q ^ ~pol_q[hpp_pkg::POL_REQ];
      end else begin
        oe_n_d[hpp_pkg::PB_REQ_A] = 1'b0;
        out_d[hpp_pkg::PB_REQ_A] = (rx_full_q & ~ack_act) ^ ~pol_q[hpp_pkg::POL_REQ];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_q <= hpp_pkg::GPIO_RESET;
      oe_n_q <= 16'hffff;
      gpin_q <= hpp_pkg::GPIO_RESET;
    end else begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
      gpin_q <= dir_q & gval_q | ~dir_q & pin_s;
    end
  end

  assign pin_out_o = out_q;
  assign pin_oe_n_o = oe_n_q;
  assign dsp_rdata_o = dsp_rdata_q;
  assign gpio_pin_value_o = gpin_q;
  assign port_pin_control_o = pin_ctrl_q;
  assign dsp_receive_full_o = hrx_full_q;
  assign dsp_send_empty_o = send_empty_q;

  a_reset_gpio_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $past(soft_reset_i) |-> pin_ctrl_q == 16'h0000 && pol_q == 4'h0)
    else $error("soft reset left control set");
  a_gpio_dir_drive: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !host_mode |=> pin_oe_n_o == ~$past(dir_q))
    else $error("gpio driver mismatch with direction");
  a_host_ignores_gpio: assert property (@(posedge clk_i) disable iff (!rstn_i)
    host_mode && !rd_act |=> pin_oe_n_o[13:0] == 14'h3fff)
    else $error("host mode drove gpio pins");
  a_rx_to_host: assert property (@(posedge clk_i) disable iff (!rstn_i)
    htx_full_q && !rx_full_q |=> rx_full_q && rx_bytes_q == $past(htx_q))
    else $error("send word not moved to host bytes");
  a_tx_to_dsp: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tx_full_q && !hrx_full_q && !wr_fall |=> hrx_full_q && hrx_q == $past(tx_bytes_q))
    else $error("host bytes not moved to receive word");
  a_host_write_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_fall && addr_q == 3'h7 |=> tx_full_q && tx_bytes_q[7:0] == $past(pin_s[7:0]))
    else $error("low byte write not loaded");
  a_read_drive: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_act |=> pin_oe_n_o[7:0] == 8'h00 && pin_out_o[7:0] == $past(rd_byte))
    else $error("read data not driven");
  a_size_8bit: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dsp_req_i.wr && dsp_req_i.size == 2'h0 |=> htx_q[23:8] == 16'h0000 && htx_full_q)
    else $error("byte write not zero extended");

  // Request pins follow the request mode; the acknowledge pin stays an input in single request mode
  a_dual_req_drive: assert property (@(posedge clk_i) disable iff (!rstn_i)
    host_mode && dual_req |=> pin_oe_n_o[15:14] == 2'h0)
    else $error("dual request pins not driven");
  a_ack_is_input: assert property (@(posedge clk_i) disable iff (!rstn_i)
    host_mode && !dual_req |=> pin_oe_n_o[15:14] == 2'h2)
    else $error("acknowledge pin driven in single request mode");
  a_gpio_out_value: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !host_mode |=> pin_out_o == $past(gval_q))
    else $error("gpio output value mismatch");
  a_mux_addr_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mux_mode && as_prev_q && !pin_s[hpp_pkg::PB_ADDR_LO] |=> addr_q == $past(pin_s[2:0]))
    else $error("muxed address not latched");
  a_cs_gates_access: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !mux_mode && !cs_act |-> !rd_act && !wr_act)
    else $error("access without chip select");
  a_idle_addr_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_act && addr_q < hpp_pkg::HA_HIGH |=> pin_out_o[7:0] == 8'h00)
    else $error("unused address read not zero");
  a_host_write_mid: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_fall && addr_q == hpp_pkg::HA_MID |=> tx_bytes_q[15:8] == $past(pin_s[7:0]))
    else $error("middle byte write not loaded");
  a_dsp_read_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dsp_req_i.rd && hrx_full_q |=> !hrx_full_q)
    else $error("receive word not freed by read");
  a_send_empty_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dsp_req_i.wr |=> !dsp_send_empty_o)
    else $error("send word not marked busy");
  a_soft_reset_gpio: assert property (@(posedge clk_i) disable iff (!rstn_i)
    soft_reset_i |=> dir_q == 16'h0000 && gval_q == 16'h0000)
    else $error("soft reset left gpio registers set");
endmodule : hpp_host_port
`default_nettype wire

// [hpp_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module hpp_host_model (
  input wire logic clk_i,
  input wire logic mux_i,
  input wire logic dual_i,
  input wire logic [15:0] pin_out_i,
  input wire logic [15:0] pin_oe_n_i,
  output logic [15:0] host_o
);
  // Idle: strobes and select inactive high, acknowledge inactive
  initial host_o = 16'hf800;

  task automatic drive(input logic [15:0] v);
    host_o = v;
  endtask : drive

  // Each phase spans six clocks so the two-stage sync sees it settle
  task automatic hold6();
    repeat (6) @(negedge clk_i);
  endtask : hold6

  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    logic [7:0] hi;
    hi = mux_i ? 8'hd9 : {5'b11011, a};
    @(negedge clk_i);
    host_o <= {hi, mux_i ? {5'h00, a} : ~host_o[7:0]};
    hold6();
    // Address stays on the shared lines while its strobe falls; the latch needs the hold
    hi[0] = mux_i ? 1'b0 : hi[0];
    host_o <= {hi, host_o[7:0]};
    hold6();
    hi[4:3] = dual_i ? {~wr, wr} : {1'b0, ~wr};
    // Released data lines show the inverse of the last value, never a kind guess
    host_o <= {hi, wr ? d : ~host_o[7:0]};
    hold6();
    q = (pin_oe_n_i[7:0] == 8'h00) ? pin_out_i[7:0] : 8'hxx;
    hi[4:3] = 2'b11;
    host_o <= {hi, host_o[7:0]};
    hold6();
    host_o <= {8'hf8, ~host_o[7:0]};
  endtask : access
endmodule : hpp_host_model
`default_nettype wire

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic soft_reset_i = 1'b0;
  logic [15:0] pin_in_i, pin_out_o, pin_oe_n_o, host_pins, gpio_pin_value_o;
  logic [15:0] port_pin_control_o, ctrl_w = '0, dv, vv, hp;
  logic ctrl_we = 1'b0, dir_we = 1'b0, val_we = 1'b0, mux = 1'b0, dual = 1'b0;
  logic pol_we = 1'b0;
  logic [1:0] sz = hpp_pkg::WS_24;
  hpp_pkg::hpp_dsp_req_t req = '{1'b0, 1'b0, hpp_pkg::WS_24, 24'h000000};
  logic [23:0] dsp_rdata_o, seen, w, r;
  logic dsp_receive_full_o, dsp_send_empty_o;
  logic [7:0] b;
  int failures = 0;
  int checks_done = 0;
  logic [23:0] exp_q[$];
  event got;

  assign pin_in_i = (~pin_oe_n_o & pin_out_o) | (pin_oe_n_o & host_pins);

  hpp_host_port i_hpp_host_port (.clk_i(clk_i), .rstn_i(rstn_i), .soft_reset_i(soft_reset_i),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
    .pin_ctrl_wdata_i(ctrl_w), .pin_ctrl_we_i(ctrl_we), .polarity_wdata_i(ctrl_w[3:0]),
    .polarity_we_i(pol_we), .gpio_dir_wdata_i(ctrl_w), .gpio_dir_we_i(dir_we),
    .gpio_val_wdata_i(ctrl_w), .gpio_val_we_i(val_we), .dsp_req_i(req),
    .dsp_rdata_o(dsp_rdata_o), .gpio_pin_value_o(gpio_pin_value_o),
    .port_pin_control_o(port_pin_control_o), .dsp_receive_full_o(dsp_receive_full_o),
    .dsp_send_empty_o(dsp_send_empty_o));

  hpp_host_model i_hpp_host_model (.clk_i(clk_i), .mux_i(mux), .dual_i(dual),
    .pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o), .host_o(host_pins));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input logic [23:0] s, input logic [23:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t saw %h want %h", $time, s, e);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic observe(input logic [23:0] v);
    seen = v;
    -> got;
  endtask : observe

  task automatic cfg(input int which, input logic [15:0] v);
    @(negedge clk_i);
    ctrl_w = v;
    ctrl_we = (which == 0);
    dir_we = (which == 1);
    val_we = (which == 2);
    pol_we = (which == 3);
    @(negedge clk_i);
    {ctrl_we, dir_we, val_we, pol_we} = 4'h0;
  endtask : cfg

  task automatic dsp(input logic wr, input logic [1:0] s, input logic [23:0] d);
    @(negedge clk_i);
    req = '{wr, ~wr, s, d};
    @(negedge clk_i);
    req = '{1'b0, 1'b0, hpp_pkg::WS_24, d};
  endtask : dsp

  // Results are compared in arrival order against the driver's notes
  always @(got) check(seen, exp_q.pop_front());

  initial begin
    #200000;
    failures++;
    final_report();
  end

  initial begin
    void'($urandom(18));
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    rstn_i = 1'b1;
    check({8'h00, port_pin_control_o}, 24'h000000);
    check({8'h00, pin_oe_n_o}, 24'h00ffff);
    check({23'h0, dsp_send_empty_o}, 24'h000001);
    repeat (4) begin
      dv = 16'($urandom);
      vv = 16'($urandom);
      hp = 16'($urandom);
      i_hpp_host_model.drive(hp);
      cfg(1, dv);
      cfg(2, vv);
      repeat (5) @(negedge clk_i);
      check({8'h00, pin_oe_n_o}, {8'h00, ~dv});
      check({8'h00, pin_out_o & dv}, {8'h00, vv & dv});
      check({8'h00, gpio_pin_value_o}, {8'h00, (dv & vv) | (~dv & hp)});
    end
    i_hpp_host_model.drive(16'hf800);
    // Pins go back to inputs first, so host mode never takes a GPIO level for a strobe
    cfg(1, 16'h0000);
    repeat (3) @(negedge clk_i);
    // Both bus modes, each with strobe and request modes set together single or dual, with host-mode pins ignoring GPIO bits
    for (int m = 0; m < 4; m++) begin
      mux = m[0];
      dual = m[1];
      sz = 2'(m % 3);
      cfg(0, {2'b00, dual, dual, mux, 4'h0, 6'h3f, 1'b0});
      check({8'h00, port_pin_control_o}, {10'h000, dual, dual, mux, 4'h0, 7'h7e});
      w = 24'($urandom);
      for (int k = 0; k < 3; k++) i_hpp_host_model.access(1'b1, 3'h5 + 3'(k), w[23 - 8*k -: 8], b);
      for (int i = 0; i < 50 && dsp_receive_full_o !== 1'b1; i++) @(negedge clk_i);
      // Read data is registered one cycle behind the full flag
      @(negedge clk_i);
      exp_q.push_back(w);
      observe(dsp_rdata_o);
      dsp(1'b0, hpp_pkg::WS_24, 24'h000000);
      @(negedge clk_i);
      check({23'h0, dsp_receive_full_o}, 24'h000000);
      w = 24'($urandom);
      dsp(1'b1, sz, w);
      check({23'h0, dsp_send_empty_o}, 24'h000000);
      repeat (4) @(negedge clk_i);
      check({23'h0, dsp_send_empty_o}, 24'h000001);
      check({22'h0, pin_oe_n_o[dual ? 15 : 14], pin_out_o[dual ? 15 : 14]}, 24'h0);
      r = '0;
      for (int k = 0; k < 3; k++) begin
        i_hpp_host_model.access(1'b0, 3'h5 + 3'(k), 8'h00, b);
        r = {r[15:0], b};
      end
      if (sz == hpp_pkg::WS_8) w[23:8] = 16'h0000;
      if (sz == hpp_pkg::WS_16) w[23:16] = 8'h00;
      exp_q.push_back(w);
      observe(r);
      i_hpp_host_model.access(1'b0, 3'h2, 8'h00, b);
      check({16'h0, b}, 24'h000000);
    end
    // Both words empty: transmit request asserted, receive request not
    check({22'h0, pin_out_o[15:14]}, 24'h000002);
    cfg(3, 16'h0004);
    repeat (2) @(negedge clk_i);
    check({22'h0, pin_out_o[15:14]}, 24'h000001);
    @(negedge clk_i);
    soft_reset_i = 1'b1;
    @(negedge clk_i);
    soft_reset_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check({8'h00, port_pin_control_o}, 24'h000000);
    check({8'h00, pin_oe_n_o}, 24'h00ffff);
    final_report();
  end
endmodule : tb
`default_nettype wire
